//--- src/wdt_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdt_regs.svh"
module wdt_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rc_clk_i,
  input  wire logic        osc_clk_i,
  input  wire logic        debug_active_i,
  input  wire logic        special_mode_i,
  input  wire logic        stop_mode_i,
  output logic             sys_reset_o,
  output logic             periodic_tick_run_o,
  output logic             irq_o
);
  import wdt_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [4:0] rate_exp(input wdt_rate_t rate);
    logic [4:0] e;
    e = `WDT_EXP_MAX;
    case (rate)
      3'h1: e = `WDT_EXP_R1;
      3'h2: e = `WDT_EXP_R2;
      3'h3: e = `WDT_EXP_R3;
      3'h4: e = `WDT_EXP_R4;
      3'h5: e = `WDT_EXP_R5;
      3'h6: e = `WDT_EXP_R6;
      default: e = `WDT_EXP_MAX;
    endcase
    return e;
  endfunction

  function automatic logic [`WDT_CNT_W-1:0] last_count(input logic [4:0] e);
    logic [`WDT_CNT_W:0] p;
    p = ({{`WDT_CNT_W{1'b0}}, 1'b1} << e) - {{`WDT_CNT_W{1'b0}}, 1'b1};
    return p[`WDT_CNT_W-1:0];
  endfunction

  function automatic logic [`WDT_CNT_W-1:0] window_start(input logic [4:0] e);
    logic [`WDT_CNT_W:0] p;
    p = {{(`WDT_CNT_W-1){1'b0}}, 2'h3} << (e - 5'd2);
    return p[`WDT_CNT_W-1:0];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [1:0] dbg_sy_r;
  logic [1:0] spc_sy_r;
  logic [1:0] stp_sy_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dbg_sy_r <= 2'h0;
      spc_sy_r <= 2'h0;
      stp_sy_r <= 2'h0;
    end
    else if (ce_i)
    begin
      dbg_sy_r <= {dbg_sy_r[0], debug_active_i};
      spc_sy_r <= {spc_sy_r[0], special_mode_i};
      stp_sy_r <= {stp_sy_r[0], stop_mode_i};
    end
  end

  logic dbg_s;
  logic spc_s;
  logic stp_s;
  assign dbg_s = dbg_sy_r[1];
  assign spc_s = spc_sy_r[1];
  assign stp_s = stp_sy_r[1];

  //////////////////////////////////////////////////////////////////////////
  // tick source

  wdt_tick_if tk ();

  wdt_tick_gen u_tick (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .rc_clk_i  (rc_clk_i),
    .osc_clk_i (osc_clk_i),
    .tk        (tk)
  );

  //////////////////////////////////////////////////////////////////////////
  // registers and state

  logic                  win_r;
  logic                  win_nxt;
  logic                  dbgs_r;
  logic                  dbgs_nxt;
  wdt_rate_t             rate_r;
  wdt_rate_t             rate_nxt;
  logic                  once_r;
  logic                  once_nxt;
  logic [2:0]            cfg_r;
  logic [2:0]            cfg_nxt;
  wdt_ev_t               stat_r;
  wdt_ev_t               stat_nxt;
  wdt_ev_t               mask_r;
  wdt_ev_t               mask_nxt;
  logic [`WDT_CNT_W-1:0] cnt_r;
  logic [`WDT_CNT_W-1:0] cnt_nxt;
  wdt_svc_state_t        svc_r;
  wdt_svc_state_t        svc_nxt;
  logic                  rst_out_r;
  logic                  rst_out_nxt;
  logic                  ack_r;
  logic                  ack_nxt;
  logic [31:0]           dat_r;
  logic [31:0]           dat_nxt;

  logic                  req;
  logic                  wr;
  logic                  rd;
  logic                  enabled;
  logic                  forced;
  logic                  halted;
  logic                  eff_win;
  logic [4:0]            eff_exp;
  logic                  expire;
  logic                  svc_wr;
  logic [7:0]            svc_val;
  logic                  early;
  logic                  ev_timeout;
  logic                  ev_window;
  logic                  ev_seq;
  logic                  restart;
  wdt_ev_t               ev_set;

  assign tk.sel_osc       = cfg_r[`WDT_CFG_SEL_LO_BIT];
  assign tk.sync_delay_en = cfg_r[`WDT_CFG_SDLY_BIT];
  assign tk.stop_mode     = stp_s;

  //////////////////////////////////////////////////////////////////////////
  // counter and service sequence

  always_comb
  begin
    req     = wb_cyc_i && wb_stb_i && !ack_r;
    wr      = req && wb_we_i && wb_sel_i[0];
    rd      = req && !wb_we_i;
    enabled = (rate_r != `WDT_RATE_OFF);
    forced  = enabled && dbg_s && !dbgs_r && spc_s;
    halted  = dbgs_r && dbg_s;
    eff_win = win_r && !forced;
    eff_exp = forced ? `WDT_EXP_MAX : rate_exp(rate_r);
    expire  = enabled && !halted && tk.tick && (cnt_r == last_count(eff_exp));
    svc_wr  = enabled && wr && (wb_adr_i == `WDT_OFS_SERVICE);
    svc_val = wb_dat_i[7:0];
    early   = eff_win && (cnt_r < window_start(eff_exp));

    ev_timeout = expire;
    ev_window  = svc_wr && early;
    ev_seq     = 1'b0;
    restart    = 1'b0;
    svc_nxt    = svc_r;
    if (svc_wr && !early)
    begin
      if (svc_val == `WDT_SVC_ARM)
      begin
        svc_nxt = WDT_SVC_ARMED;
      end
      else if (svc_val == `WDT_SVC_RESTART && svc_r == WDT_SVC_ARMED)
      begin
        svc_nxt = WDT_SVC_IDLE;
        restart = 1'b1;
      end
      else
      begin
        svc_nxt = WDT_SVC_IDLE;
        ev_seq  = 1'b1;
      end
    end
    rst_out_nxt = ev_timeout || ev_window || ev_seq;

    cnt_nxt = cnt_r;
    if (!enabled || restart || rst_out_nxt)
    begin
      cnt_nxt = {`WDT_CNT_W{1'b0}};
    end
    else if (!halted && tk.tick)
    begin
      cnt_nxt = cnt_r + {{(`WDT_CNT_W-1){1'b0}}, 1'b1};
    end
    if (rst_out_nxt)
    begin
      svc_nxt = WDT_SVC_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register writes and reads

  always_comb
  begin
    ev_set   = 3'h0;
    ev_set[`WDT_EV_TIMEOUT_BIT] = ev_timeout;
    ev_set[`WDT_EV_WINDOW_BIT]  = ev_window;
    ev_set[`WDT_EV_SEQ_BIT]     = ev_seq;
    win_nxt  = win_r;
    dbgs_nxt = dbgs_r;
    rate_nxt = rate_r;
    once_nxt = once_r;
    cfg_nxt  = cfg_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    ack_nxt  = req;
    dat_nxt  = 32'h0;

    if (wr && wb_adr_i == `WDT_OFS_CTRL)
    begin
      dbgs_nxt = wb_dat_i[`WDT_CTRL_DBGS_BIT];
      if (!wb_dat_i[`WDT_CTRL_WMASK_BIT] && (!once_r || spc_s))
      begin
        win_nxt  = wb_dat_i[`WDT_CTRL_WIN_BIT];
        rate_nxt = wb_dat_i[`WDT_CTRL_RATE_HI:`WDT_CTRL_RATE_LO];
        once_nxt = 1'b1;
      end
    end
    else if (wr && wb_adr_i == `WDT_OFS_CLKCFG)
    begin
      cfg_nxt = wb_dat_i[`WDT_CFG_SDLY_BIT:`WDT_CFG_SEL_LO_BIT];
    end
    else if (wr && wb_adr_i == `WDT_OFS_MASK)
    begin
      mask_nxt = wb_dat_i[`WDT_EV_W-1:0];
    end

    if (rd && wb_adr_i == `WDT_OFS_CTRL)
    begin
      dat_nxt[`WDT_CTRL_WIN_BIT]  = win_r;
      dat_nxt[`WDT_CTRL_DBGS_BIT] = dbgs_r;
      dat_nxt[`WDT_CTRL_RATE_HI:`WDT_CTRL_RATE_LO] = rate_r;
    end
    else if (rd && wb_adr_i == `WDT_OFS_CLKCFG)
    begin
      dat_nxt[`WDT_CFG_SDLY_BIT:`WDT_CFG_SEL_LO_BIT] = cfg_r;
    end
    else if (rd && wb_adr_i == `WDT_OFS_STATUS)
    begin
      dat_nxt[`WDT_EV_W-1:0] = stat_r;
      stat_nxt = 3'h0;
    end
    else if (rd && wb_adr_i == `WDT_OFS_MASK)
    begin
      dat_nxt[`WDT_EV_W-1:0] = mask_r;
    end
    else if (rd && wb_adr_i == `WDT_OFS_COUNT)
    begin
      dat_nxt[`WDT_CNT_W-1:0] = cnt_r;
    end
    stat_nxt = stat_nxt | ev_set;
  end

  //////////////////////////////////////////////////////////////////////////
  // state registers

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      win_r     <= 1'b0;
      dbgs_r    <= 1'b0;
      rate_r    <= `WDT_RST_RATE;
      once_r    <= 1'b0;
      cfg_r     <= `WDT_RST_CFG;
      stat_r    <= 3'h0;
      mask_r    <= `WDT_RST_MASK;
      cnt_r     <= {`WDT_CNT_W{1'b0}};
      svc_r     <= WDT_SVC_IDLE;
      rst_out_r <= 1'b0;
      ack_r     <= 1'b0;
      dat_r     <= 32'h0;
    end
    else if (ce_i)
    begin
      win_r     <= win_nxt;
      dbgs_r    <= dbgs_nxt;
      rate_r    <= rate_nxt;
      once_r    <= once_nxt;
      cfg_r     <= cfg_nxt;
      stat_r    <= stat_nxt;
      mask_r    <= mask_nxt;
      cnt_r     <= cnt_nxt;
      svc_r     <= svc_nxt;
      rst_out_r <= rst_out_nxt;
      ack_r     <= ack_nxt;
      dat_r     <= dat_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  assign wb_ack_o            = ack_r;
  assign wb_dat_o            = dat_r;
  assign sys_reset_o         = rst_out_r;
  assign periodic_tick_run_o = !halted;
  assign irq_o               = |(stat_r & mask_r);
endmodule
`default_nettype wire

//--- src/wdt_regs.svh
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// register byte offsets
`define WDT_OFS_CTRL      8'h00
`define WDT_OFS_SERVICE   8'h04
`define WDT_OFS_CLKCFG    8'h08
`define WDT_OFS_STATUS    8'h0c
`define WDT_OFS_MASK      8'h10
`define WDT_OFS_COUNT     8'h14

// control register fields
`define WDT_CTRL_WIN_BIT   7
`define WDT_CTRL_DBGS_BIT  6
`define WDT_CTRL_WMASK_BIT 5
`define WDT_CTRL_RATE_HI   2
`define WDT_CTRL_RATE_LO   0

// clock configuration fields
`define WDT_CFG_SEL_LO_BIT 0
`define WDT_CFG_SEL_HI_BIT 1
`define WDT_CFG_SDLY_BIT   2

// status and mask fields
`define WDT_EV_TIMEOUT_BIT 0
`define WDT_EV_WINDOW_BIT  1
`define WDT_EV_SEQ_BIT     2
`define WDT_EV_W           3

// reset values and the rate code that disables the counter
`define WDT_RST_RATE   3'h0
`define WDT_RST_CFG    3'h0
`define WDT_RST_MASK   3'h0
`define WDT_RATE_OFF   3'h0

// service values
`define WDT_SVC_ARM      8'h55
`define WDT_SVC_RESTART  8'haa

// timeout exponents per rate code and in forced debug operation
`define WDT_EXP_R1  5'd14
`define WDT_EXP_R2  5'd16
`define WDT_EXP_R3  5'd18
`define WDT_EXP_R4  5'd20
`define WDT_EXP_R5  5'd22
`define WDT_EXP_R6  5'd23
`define WDT_EXP_MAX 5'd24

// counter width and tick counts after stop exit
`define WDT_CNT_W        24
`define WDT_STOP_SYNC_TICKS 4'h4

`endif

//--- src/wdt_pkg.sv
`default_nettype none
package wdt_pkg;
  typedef enum logic [0:0] {
    WDT_SVC_IDLE  = 1'b0,
    WDT_SVC_ARMED = 1'b1
  } wdt_svc_state_t;

  typedef logic [2:0] wdt_rate_t;
  typedef logic [2:0] wdt_ev_t;
endpackage
`default_nettype wire

//--- src/wdt_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface wdt_tick_if;
  logic sel_osc;
  logic sync_delay_en;
  logic stop_mode;
  logic tick;

  modport ctrl (output sel_osc, output sync_delay_en, output stop_mode, input tick);
  modport gen  (input sel_osc, input sync_delay_en, input stop_mode, output tick);
endinterface
`default_nettype wire

//--- src/wdt_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdt_regs.svh"
module wdt_tick_gen (
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  input  wire logic  ce_i,
  input  wire logic  rc_clk_i,
  input  wire logic  osc_clk_i,
  wdt_tick_if.gen    tk
);
  import wdt_pkg::*;

  logic [2:0] rc_sh_r;
  logic [2:0] rc_sh_nxt;
  logic [2:0] osc_sh_r;
  logic [2:0] osc_sh_nxt;
  logic       stop_d_r;
  logic       stop_d_nxt;
  logic [3:0] hold_r;
  logic [3:0] hold_nxt;
  logic       rc_edge;
  logic       osc_edge;
  logic       raw_tick;

  //////////////////////////////////////////////////////////////////////////
  // two-flop sync, third flop for rising edge
  always_comb
  begin
    rc_sh_nxt  = {rc_sh_r[1:0], rc_clk_i};
    osc_sh_nxt = {osc_sh_r[1:0], osc_clk_i};
    rc_edge    = rc_sh_r[1] & ~rc_sh_r[2];
    osc_edge   = osc_sh_r[1] & ~osc_sh_r[2];
    raw_tick   = tk.sel_osc ? osc_edge : rc_edge;
    stop_d_nxt = tk.stop_mode;
    hold_nxt   = hold_r;
    if (stop_d_r && !tk.stop_mode && tk.sync_delay_en && !tk.sel_osc)
    begin
      hold_nxt = `WDT_STOP_SYNC_TICKS;
    end
    else if (hold_r != 4'h0 && raw_tick)
    begin
      hold_nxt = hold_r - 4'h1;
    end
    tk.tick = raw_tick && !tk.stop_mode && (hold_r == 4'h0);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rc_sh_r  <= 3'h0;
      osc_sh_r <= 3'h0;
      stop_d_r <= 1'b0;
      hold_r   <= 4'h0;
    end
    else if (ce_i)
    begin
      rc_sh_r  <= rc_sh_nxt;
      osc_sh_r <= osc_sh_nxt;
      stop_d_r <= stop_d_nxt;
      hold_r   <= hold_nxt;
    end
  end
endmodule
`default_nettype wire

//--- testbench/wdt_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdt_regs.svh"
module wdt_top_chk (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  input  wire logic        debug_active_i,
  input  wire logic        sys_reset_o,
  input  wire logic        periodic_tick_run_o,
  input  wire logic        irq_o
);
  logic       we_r;
  logic       we_nxt;
  logic [7:0] adr_r;
  logic [7:0] adr_nxt;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////
  // capture of the request that the pending ack answers
  always_comb
  begin
    we_nxt = we_r;
    adr_nxt = adr_r;
    if (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i)
    begin
      we_nxt = wb_we_i;
      adr_nxt = wb_adr_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    we_r <= we_nxt;
    adr_r <= adr_nxt;
  end

  ////////////////////////////////////////////////////////////////
  ack_one_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("request not acked after one cycle");
  ack_drop_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  reset_pulse_a: assert property (sys_reset_o && ce_i |=> !sys_reset_o)
    else $error("system reset pulse longer than one cycle");
  irq_clear_a: assert property ($fell(irq_o) |-> wb_ack_o)
    else $error("interrupt dropped without a bus access");
  run_debug_a: assert property (!periodic_tick_run_o |->
    $past(debug_active_i, 1) || $past(debug_active_i, 2) || $past(debug_active_i, 3))
    else $error("tick counter halted outside debug");
  unmapped_zero_a: assert property (wb_ack_o && !we_r && adr_r >= 8'h18 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  ctrl_mask_a: assert property (wb_ack_o && !we_r && adr_r == `WDT_OFS_CTRL |->
    wb_dat_o[31:8] == 24'h0 && !wb_dat_o[5])
    else $error("write mask bit or upper bits read back");
  count_width_a: assert property (wb_ack_o && !we_r && adr_r == `WDT_OFS_COUNT |->
    wb_dat_o[31:24] == 8'h0)
    else $error("counter wider than 24 bits");
  reset_idle_a: assert property ($fell(rst_i) |->
    !wb_ack_o && !sys_reset_o && !irq_o && periodic_tick_run_o)
    else $error("outputs not idle after reset");

  cover property ($rose(sys_reset_o));
  cover property ($rose(irq_o));
  cover property ($fell(periodic_tick_run_o));
endmodule

bind wdt_top wdt_top_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .debug_active_i(debug_active_i),
  .sys_reset_o(sys_reset_o), .periodic_tick_run_o(periodic_tick_run_o), .irq_o(irq_o));
`default_nettype wire

//--- testbench/wdt_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdt_regs.svh"
module wdt_top_tb;
  logic        clk_i;
  logic        rst_i;
  logic        req;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rd;
  logic        ack;
  logic        rc;
  logic        osc;
  logic        osc_on;
  logic        stp;
  logic        dbg;
  logic        spec;
  logic        sys_rst;
  logic        run;
  logic        irq;
  logic        tick_on;
  logic [31:0] rdat;
  logic [31:0] c;
  int          rst_seen;
  int          bad_count;
  int          total_checks;

  wdt_top uut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rd),
    .wb_ack_o(ack), .rc_clk_i(rc), .osc_clk_i(osc), .debug_active_i(dbg),
    .special_mode_i(spec), .stop_mode_i(stp), .sys_reset_o(sys_rst),
    .periodic_tick_run_o(run), .irq_o(irq)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // tick pins idle low whenever their enable is off
  always @(posedge clk_i)
    rc <= tick_on & ~rc;

  always @(posedge clk_i)
    osc <= osc_on & ~osc;

  always @(posedge clk_i)
    if (sys_rst === 1'b1)
      rst_seen <= rst_seen + 1;

  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
    end
    while (ack !== 1'b1);
    rdat = rd;
    req <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask

  task automatic svc(input logic [7:0] v);
    bus(1'b1, `WDT_OFS_SERVICE, {24'h0, v});
  endtask

  // exactly k rising edges on the rc pin, then time to pass the sync stages
  task automatic rc_ticks(input int k);
    tick_on <= 1'b1;
    repeat (2 * k) @(posedge clk_i);
    tick_on <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rchk(`WDT_OFS_CTRL, 32'h0);
    rchk(8'h20, 32'h0);
    bus(1'b1, `WDT_OFS_CTRL, 32'h23);
    rchk(`WDT_OFS_CTRL, 32'h0);
    bus(1'b1, `WDT_OFS_CTRL, 32'h01);
    rchk(`WDT_OFS_CTRL, 32'h01);
    bus(1'b1, `WDT_OFS_CTRL, 32'h82);
    rchk(`WDT_OFS_CTRL, 32'h01);
    $display("register test done");
  endtask

  task automatic t_svc;
    tick_on <= 1'b1;
    repeat (200) @(posedge clk_i);
    bus(1'b0, `WDT_OFS_COUNT, 32'h0);
    chk({31'h0, rdat > 32'd50}, 32'h1);
    svc(`WDT_SVC_ARM);
    svc(`WDT_SVC_ARM);
    svc(`WDT_SVC_RESTART);
    bus(1'b0, `WDT_OFS_COUNT, 32'h0);
    chk({31'h0, rdat < 32'd16}, 32'h1);
    chk(rst_seen, 32'h0);
    bus(1'b1, `WDT_OFS_MASK, 32'h4);
    svc(8'h12);
    repeat (3) @(posedge clk_i);
    chk(rst_seen, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rchk(`WDT_OFS_STATUS, 32'h4);
    chk({31'h0, irq}, 32'h0);
    $display("service test done");
  endtask

  task automatic t_dbg;
    dbg <= 1'b1;
    repeat (5) @(posedge clk_i);
    bus(1'b0, `WDT_OFS_COUNT, 32'h0);
    c = rdat;
    repeat (40) @(posedge clk_i);
    bus(1'b0, `WDT_OFS_COUNT, 32'h0);
    chk({31'h0, rdat != c}, 32'h1);
    bus(1'b1, `WDT_OFS_CTRL, 32'h41);
    chk({31'h0, run}, 32'h0);
    bus(1'b0, `WDT_OFS_COUNT, 32'h0);
    c = rdat;
    repeat (40) @(posedge clk_i);
    rchk(`WDT_OFS_COUNT, c);
    dbg <= 1'b0;
    bus(1'b1, `WDT_OFS_CTRL, 32'h01);
    $display("debug test done");
  endtask

  task automatic t_sel;
    bus(1'b1, `WDT_OFS_CLKCFG, 32'h1);
    bus(1'b0, `WDT_OFS_COUNT, 32'h0);
    c = rdat;
    repeat (40) @(posedge clk_i);
    rchk(`WDT_OFS_COUNT, c);
    osc_on <= 1'b1;
    repeat (20) @(posedge clk_i);
    osc_on <= 1'b0;
    repeat (6) @(posedge clk_i);
    rchk(`WDT_OFS_COUNT, c + 32'ha);
    bus(1'b1, `WDT_OFS_CLKCFG, 32'h0);
    $display("clock select test done");
  endtask

  task automatic t_stop;
    tick_on <= 1'b0;
    bus(1'b1, `WDT_OFS_CLKCFG, 32'h4);
    repeat (6) @(posedge clk_i);
    bus(1'b0, `WDT_OFS_COUNT, 32'h0);
    c = rdat;
    stp <= 1'b1;
    repeat (4) @(posedge clk_i);
    rc_ticks(4);
    rchk(`WDT_OFS_COUNT, c);
    stp <= 1'b0;
    repeat (4) @(posedge clk_i);
    rc_ticks(6);
    rchk(`WDT_OFS_COUNT, c + 32'h2);
    bus(1'b1, `WDT_OFS_CLKCFG, 32'h0);
    tick_on <= 1'b1;
    $display("stop test done");
  endtask

  task automatic t_win;
    int n;
    spec <= 1'b1;
    repeat (4) @(posedge clk_i);
    bus(1'b1, `WDT_OFS_CTRL, 32'h81);
    rchk(`WDT_OFS_CTRL, 32'h81);
    svc(`WDT_SVC_ARM);
    repeat (3) @(posedge clk_i);
    chk(rst_seen, 32'h2);
    rchk(`WDT_OFS_STATUS, 32'h2);
    n = 0;
    rdat = 32'h0;
    while (rdat < 32'd12300 && n < 9000)
    begin
      bus(1'b0, `WDT_OFS_COUNT, 32'h0);
      n++;
    end
    svc(`WDT_SVC_ARM);
    svc(`WDT_SVC_RESTART);
    chk(rst_seen, 32'h2);
    bus(1'b0, `WDT_OFS_COUNT, 32'h0);
    chk({31'h0, rdat < 32'd16}, 32'h1);
    dbg <= 1'b1;
    repeat (4) @(posedge clk_i);
    svc(`WDT_SVC_ARM);
    svc(`WDT_SVC_RESTART);
    repeat (3) @(posedge clk_i);
    chk(rst_seen, 32'h2);
    dbg <= 1'b0;
    repeat (4) @(posedge clk_i);
    $display("window test done");
  endtask

  task automatic t_to;
    int n;
    bus(1'b1, `WDT_OFS_CTRL, 32'h01);
    svc(`WDT_SVC_ARM);
    svc(`WDT_SVC_RESTART);
    n = 0;
    while (rst_seen == 2 && n < 40000)
    begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, n > 32740 && n < 32800}, 32'h1);
    rchk(`WDT_OFS_STATUS, 32'h1);
    $display("timeout test done");
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    {req, we, adr, wdat, rc, osc, osc_on, stp, dbg, spec, tick_on} = '0;
    rst_i = 1'b1;
    rst_seen = 0;
    bad_count = 0;
    total_checks = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_svc();
    t_dbg();
    t_sel();
    t_stop();
    t_win();
    t_to();
    summarize();
  end

  initial
  begin
    repeat (90000) @(posedge clk_i);
    bad_count++;
    summarize();
  end
endmodule
`default_nettype wire
